/* File: hdl/imr_pkg.sv */
// Package: constants for the indirect store / return / reset execution block.
// Assumes a 14-bit instruction word, 16-bit pointers and a 15-bit program counter.
package imr_pkg;
  localparam int IMR_PC_W = 15;
  localparam int IMR_PTR_W = 16;
  localparam int IMR_DATA_W = 8;
  localparam int IMR_STK_DEPTH = 16;
  localparam int IMR_STK_AW = 4;
  // Wishbone register byte offsets
  localparam logic [7:0] IMR_OFS_ACC = 8'h00;
  localparam logic [7:0] IMR_OFS_PTR0 = 8'h04;
  localparam logic [7:0] IMR_OFS_PTR1 = 8'h08;
  localparam logic [7:0] IMR_OFS_PC = 8'h0C;
  localparam logic [7:0] IMR_OFS_INTCTL = 8'h10;
  localparam logic [7:0] IMR_OFS_PWRCTL = 8'h14;
  localparam logic [7:0] IMR_OFS_STATUS = 8'h18;
  localparam logic [7:0] IMR_OFS_INSTR = 8'h1C;
  localparam logic [7:0] IMR_OFS_PUSH = 8'h20;
  // Field positions
  localparam int IMR_IRQ_EN_BIT = 7;
  localparam int IMR_RST_FLAG_BIT = 2;
  // Reset values
  localparam logic [7:0] IMR_INTCTL_RST = 8'h00;
  localparam logic [7:0] IMR_PWRCTL_RST = 8'h04;
  localparam logic [7:0] IMR_STATUS_RST = 8'h00;
  // Instruction encodings
  localparam logic [13:0] IMR_OP_NOP = 14'h0000;
  localparam logic [13:0] IMR_OP_RESET = 14'h0001;
  localparam logic [13:0] IMR_OP_RETFI = 14'h0009;
  localparam logic [10:0] IMR_OP_STORE_HI = 11'h002;
  localparam logic [6:0] IMR_OP_STREL_HI = 7'h7F;
  // Pointer mode field values
  localparam logic [1:0] IMR_MODE_PREINC = 2'h0;
  localparam logic [1:0] IMR_MODE_PREDEC = 2'h1;
  localparam logic [1:0] IMR_MODE_POSTINC = 2'h2;
  localparam logic [1:0] IMR_MODE_POSTDEC = 2'h3;
  // Instruction cycle counts
  localparam int IMR_RETFI_CYCLES = 2;
  localparam int IMR_RESET_HOLD = 4;
  typedef enum logic [1:0] {
    IMR_ST_IDLE = 2'b00,
    IMR_ST_EXEC = 2'b01,
    IMR_ST_RET2 = 2'b11,
    IMR_ST_RST = 2'b10
  } imr_state_t;
endpackage

/* File: hdl/imr_ea_calc.sv */
// Effective-address and pointer-update calculator for the indirect store.
// Pure combinational; caller supplies mode, relative flag and offset.
`timescale 1ns/10ps
module imr_ea_calc
  import imr_pkg::*;
(
  input wire logic [imr_pkg::IMR_PTR_W-1:0] ptr, // Current pointer
  input wire logic [1:0] mode, // Pointer mode field
  input wire logic rel, // Relative-offset form
  input wire logic [5:0] offs, // Signed offset
  output logic [imr_pkg::IMR_PTR_W-1:0] eff_addr, // Effective address
  output logic [imr_pkg::IMR_PTR_W-1:0] ptr_new // Pointer after store
);
  import imr_pkg::*;
  logic [IMR_PTR_W-1:0] inc;
  logic [IMR_PTR_W-1:0] dec;
  logic [IMR_PTR_W-1:0] ofs_ext;
  // 16-bit arithmetic wraps naturally
  assign inc = ptr + 16'h0001;
  assign dec = ptr - 16'h0001;
  assign ofs_ext = {{10{offs[5]}}, offs};
  always_comb
  begin
    eff_addr = ptr;
    ptr_new = ptr;
    if (rel)
    begin
      eff_addr = ptr + ofs_ext;
      ptr_new = ptr;
    end
    else
    begin
      case (mode)
        IMR_MODE_PREINC:
        begin
          eff_addr = inc;
          ptr_new = inc;
        end
        IMR_MODE_PREDEC:
        begin
          eff_addr = dec;
          ptr_new = dec;
        end
        IMR_MODE_POSTINC:
        begin
          eff_addr = ptr;
          ptr_new = inc;
        end
        default:
        begin
          eff_addr = ptr;
          ptr_new = dec;
        end
      endcase
    end
  end
endmodule // imr_ea_calc

/* File: hdl/imr_ret_stack.sv */
// Hardware return stack, 16 entries; pointer wraps on overflow/underflow, depth saturates at 16 and 0.
// Push and pop are one-cycle strobes from the same clock domain.
`timescale 1ns/10ps
module imr_ret_stack
  import imr_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic push, // Push strobe
  input wire logic [imr_pkg::IMR_PC_W-1:0] push_data, // Address to push
  input wire logic pop, // Pop strobe
  output logic [imr_pkg::IMR_PC_W-1:0] top, // Current top-of-stack
  output logic [imr_pkg::IMR_STK_AW:0] depth // Entries held
);
  import imr_pkg::*;
  logic [IMR_PC_W-1:0] mem [IMR_STK_DEPTH];
  logic [IMR_STK_AW-1:0] sp_reg;
  logic [IMR_STK_AW:0] depth_reg;
  assign top = mem[sp_reg - 4'h1];
  assign depth = depth_reg;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sp_reg <= 4'h0;
      depth_reg <= 5'h00;
    end
    else if (push)
    begin
      sp_reg <= sp_reg + 4'h1;
      if (depth_reg != 5'h10)
        depth_reg <= depth_reg + 5'h01;
    end
    else if (pop)
    begin
      sp_reg <= sp_reg - 4'h1;
      if (depth_reg != 5'h00)
        depth_reg <= depth_reg - 5'h01;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem[sp_reg] <= push_data;
  end
endmodule // imr_ret_stack

/* File: hdl/imr_exec.sv */
// Execution unit for indirect store, no-operation, software reset and return
// from interrupt. Assumes instructions are issued over Wishbone by software.
`timescale 1ns/10ps
module imr_exec
  import imr_pkg::*;
(
  input wire logic sys_clk, // 200 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  output logic mem_we, // Data memory write strobe
  output logic [imr_pkg::IMR_PTR_W-1:0] mem_addr, // Data memory address
  output logic [imr_pkg::IMR_DATA_W-1:0] mem_wdata, // Data memory write data
  output logic dev_reset_n // Device reset request, active low
);
  import imr_pkg::*;
  logic rst_s1_reg, rst_s2_reg, srst_n;
  logic [IMR_DATA_W-1:0] acc_reg;
  logic [IMR_PTR_W-1:0] ptr0_reg, ptr1_reg, ptr_sel, eff_addr, ptr_new;
  logic [IMR_PC_W-1:0] pc_reg, stk_top;
  logic [IMR_STK_AW:0] stk_depth;
  logic [7:0] intctl_reg, pwrctl_reg, status_reg;
  logic [13:0] instr_reg;
  logic [1:0] cnt_reg;
  logic [2:0] rst_cnt_reg;
  imr_state_t state_reg;
  logic wb_req, wr_hit, stk_pop, stk_push, ack_reg, soft_rst_n;
  logic is_store, is_rel, ptr_idx;
  logic [1:0] st_mode;
  logic [5:0] st_offs;
  logic [31:0] rd_mux, dat_reg;
  logic mem_we_reg, dev_rst_n_reg;
  logic [IMR_PTR_W-1:0] mem_addr_reg;
  logic [IMR_DATA_W-1:0] mem_wdata_reg;
  // Reset release through two flops; software reset joins only dev_rst_n_reg, which drives dev_reset_n and the return stack reset
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign soft_rst_n = (state_reg != IMR_ST_RST);
  assign srst_n = rst_s2_reg;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_hit = wb_req && wb_we_i && wb_sel_i[0];
  // Instruction field decode
  assign is_store = (instr_reg[13:3] == IMR_OP_STORE_HI) || (instr_reg[13:7] == IMR_OP_STREL_HI);
  assign is_rel = (instr_reg[13:7] == IMR_OP_STREL_HI);
  assign ptr_idx = is_rel ? instr_reg[6] : instr_reg[2];
  assign st_mode = instr_reg[1:0];
  assign st_offs = instr_reg[5:0];
  assign ptr_sel = ptr_idx ? ptr1_reg : ptr0_reg;
  imr_ea_calc u_ea (
    .ptr(ptr_sel),
    .mode(st_mode),
    .rel(is_rel),
    .offs(st_offs),
    .eff_addr(eff_addr),
    .ptr_new(ptr_new)
  );
  assign stk_pop = (state_reg == IMR_ST_EXEC) && (instr_reg == IMR_OP_RETFI);
  assign stk_push = wr_hit && (wb_adr_i == IMR_OFS_PUSH);
  imr_ret_stack u_stk (
    .clk(sys_clk),
    .rst_n(dev_rst_n_reg), // Emptied by software reset as well
    .push(stk_push),
    .push_data(wb_dat_i[IMR_PC_W-1:0]),
    .pop(stk_pop),
    .top(stk_top),
    .depth(stk_depth)
  );
  // Instruction sequencer; writing the instruction register issues one
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      state_reg <= IMR_ST_IDLE;
      instr_reg <= IMR_OP_NOP;
      cnt_reg <= 2'h0;
      rst_cnt_reg <= 3'h0;
    end
    else
    begin
      case (state_reg)
        IMR_ST_IDLE:
        begin
          if (wr_hit && wb_adr_i == IMR_OFS_INSTR)
          begin
            instr_reg <= wb_dat_i[13:0];
            state_reg <= IMR_ST_EXEC;
          end
        end
        IMR_ST_EXEC:
        begin
          if (instr_reg == IMR_OP_RETFI)
          begin
            state_reg <= IMR_ST_RET2;
            cnt_reg <= 2'(IMR_RETFI_CYCLES - 1);
          end
          else if (instr_reg == IMR_OP_RESET)
          begin
            state_reg <= IMR_ST_RST;
            rst_cnt_reg <= 3'(IMR_RESET_HOLD - 1);
          end
          else
            state_reg <= IMR_ST_IDLE;
        end
        IMR_ST_RET2:
        begin
          cnt_reg <= cnt_reg - 2'h1;
          if (cnt_reg == 2'h1)
            state_reg <= IMR_ST_IDLE;
        end
        IMR_ST_RST:
        begin
          rst_cnt_reg <= rst_cnt_reg - 3'h1;
          if (rst_cnt_reg == 3'h0)
            state_reg <= IMR_ST_IDLE;
        end
        default: state_reg <= IMR_ST_IDLE;
      endcase
    end
  end
  // Core registers; software reset restores them to reset values
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      acc_reg <= 8'h00;
      ptr0_reg <= 16'h0000;
      ptr1_reg <= 16'h0000;
      pc_reg <= 15'h0000;
      intctl_reg <= IMR_INTCTL_RST;
      status_reg <= IMR_STATUS_RST;
    end
    else if (state_reg == IMR_ST_RST)
    begin
      acc_reg <= 8'h00;
      ptr0_reg <= 16'h0000;
      ptr1_reg <= 16'h0000;
      pc_reg <= 15'h0000;
      intctl_reg <= IMR_INTCTL_RST;
      status_reg <= IMR_STATUS_RST;
    end
    else if (state_reg == IMR_ST_EXEC)
    begin
      if (instr_reg == IMR_OP_RETFI)
      begin
        pc_reg <= stk_top;
        intctl_reg[IMR_IRQ_EN_BIT] <= 1'b1;
      end
      else
      begin
        pc_reg <= pc_reg + 15'h0001;
        if (is_store && !ptr_idx)
          ptr0_reg <= ptr_new; // status_reg untouched
        if (is_store && ptr_idx)
          ptr1_reg <= ptr_new;
      end
    end
    else if (wr_hit)
    begin
      case (wb_adr_i)
        IMR_OFS_ACC: acc_reg <= wb_dat_i[7:0];
        IMR_OFS_PTR0: ptr0_reg <= wb_dat_i[15:0];
        IMR_OFS_PTR1: ptr1_reg <= wb_dat_i[15:0];
        IMR_OFS_PC: pc_reg <= wb_dat_i[14:0];
        IMR_OFS_INTCTL: intctl_reg <= wb_dat_i[7:0];
        IMR_OFS_STATUS: status_reg <= wb_dat_i[7:0];
        default: acc_reg <= acc_reg;
      endcase
    end
  end
  // Power control survives software reset only as cleared flag
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
      pwrctl_reg <= IMR_PWRCTL_RST;
    else if (state_reg == IMR_ST_EXEC && instr_reg == IMR_OP_RESET)
      pwrctl_reg[IMR_RST_FLAG_BIT] <= 1'b0;
    else if (wr_hit && wb_adr_i == IMR_OFS_PWRCTL)
      pwrctl_reg <= wb_dat_i[7:0];
  end
  // Data memory write; no window storage exists
  always_ff @(posedge sys_clk or negedge srst_n)
  begin
    if (!srst_n)
    begin
      mem_we_reg <= 1'b0;
      mem_addr_reg <= 16'h0000;
      mem_wdata_reg <= 8'h00;
    end
    else
    begin
      mem_we_reg <= (state_reg == IMR_ST_EXEC) && is_store;
      if ((state_reg == IMR_ST_EXEC) && is_store)
      begin
        mem_addr_reg <= eff_addr;
        mem_wdata_reg <= acc_reg;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      dev_rst_n_reg <= 1'b0;
    else
      dev_rst_n_reg <= soft_rst_n && rst_s2_reg;
  end
  always_comb
  begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      IMR_OFS_ACC: rd_mux = {24'h000000, acc_reg};
      IMR_OFS_PTR0: rd_mux = {16'h0000, ptr0_reg};
      IMR_OFS_PTR1: rd_mux = {16'h0000, ptr1_reg};
      IMR_OFS_PC: rd_mux = {17'h00000, pc_reg};
      IMR_OFS_INTCTL: rd_mux = {24'h000000, intctl_reg};
      IMR_OFS_PWRCTL: rd_mux = {24'h000000, pwrctl_reg};
      IMR_OFS_STATUS: rd_mux = {24'h000000, status_reg};
      IMR_OFS_INSTR: rd_mux = {16'h0000, (state_reg != IMR_ST_IDLE), 1'b0, instr_reg};
      IMR_OFS_PUSH: rd_mux = {27'h0000000, stk_depth};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end
    else
    begin
      ack_reg <= wb_req;
      dat_reg <= rd_mux;
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign dev_reset_n = dev_rst_n_reg;
  property p_store_write;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_store) |=> mem_we && mem_wdata == $past(acc_reg);
  endproperty
  a_store_write: assert property (p_store_write) else $error("store not written");
  property p_preinc;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_store && !is_rel && st_mode == IMR_MODE_PREINC)
      |=> mem_addr == $past(ptr_sel) + 16'h0001;
  endproperty
  a_preinc: assert property (p_preinc) else $error("preinc address wrong");
  property p_postdec;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_store && !is_rel && st_mode == IMR_MODE_POSTDEC && !ptr_idx)
      |=> mem_addr == $past(ptr0_reg) && ptr0_reg == $past(ptr0_reg) - 16'h0001;
  endproperty
  a_postdec: assert property (p_postdec) else $error("postdec wrong");
  property p_rel_keep;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_rel && !ptr_idx) |=> $stable(ptr0_reg);
  endproperty
  a_rel_keep: assert property (p_rel_keep) else $error("relative changed pointer");
  property p_wrap;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_store && !is_rel && !ptr_idx
       && st_mode == IMR_MODE_PREINC && ptr0_reg == 16'hFFFF) |=> ptr0_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_flags;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && is_store) |=> $stable(status_reg);
  endproperty
  a_flags: assert property (p_flags) else $error("store changed flags");
  sequence s_ret_issue;
    state_reg == IMR_ST_EXEC && instr_reg == IMR_OP_RETFI;
  endsequence
  sequence s_ret_done;
    state_reg == IMR_ST_RET2 ##1 state_reg == IMR_ST_IDLE;
  endsequence
  property p_ret_pc;
    @(posedge sys_clk) disable iff (!srst_n)
      s_ret_issue |=> pc_reg == $past(stk_top) && intctl_reg[IMR_IRQ_EN_BIT];
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc or enable wrong");
  property p_ret_len;
    @(posedge sys_clk) disable iff (!srst_n)
      s_ret_issue |=> s_ret_done;
  endproperty
  a_ret_len: assert property (p_ret_len) else $error("return not two cycles");
  property p_nop;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && instr_reg == IMR_OP_NOP)
      |=> pc_reg == $past(pc_reg) + 15'h0001 && $stable(acc_reg) && !mem_we
          && state_reg == IMR_ST_IDLE;
  endproperty
  a_nop: assert property (p_nop) else $error("nop misbehaved");
  property p_reset;
    @(posedge sys_clk) disable iff (!srst_n)
      (state_reg == IMR_ST_EXEC && instr_reg == IMR_OP_RESET)
      |=> !pwrctl_reg[IMR_RST_FLAG_BIT] ##1 (pc_reg == 15'h0000 && !dev_reset_n);
  endproperty
  a_reset: assert property (p_reset) else $error("software reset wrong");
endmodule // imr_exec

/* File: tb/imr_exec_tb_top.sv */
// Self-checking bench for the indirect store / return / reset execution unit.
// Assumes the register map, encodings and one-cycle Wishbone answer of imr_pkg.
`timescale 1ns/10ps
module indirect_move_return_reset_exec_tb_top;
  import imr_pkg::*;
  logic sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, mem_we, dev_reset_n;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i;
  logic [IMR_PTR_W-1:0] mem_addr;
  logic [IMR_DATA_W-1:0] mem_wdata;
  logic [14:0] a1, a2;
  logic [63:0] rd_q[$];
  logic [31:0] mem_q[$];
  logic [63:0] note;
  int err_total, num_checks, n;

  imr_exec DUT (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .dev_reset_n(dev_reset_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic summarize();
    if (rd_q.size() != 0 || mem_q.size() != 0)
      err_total++;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] mask, input logic [31:0] got);
    num_checks++;
    if ((got & mask) !== (exp & mask))
    begin
      err_total++;
      $display("unexpected read at %0t: expected %h got %h", $time, exp & mask, got & mask);
    end
  endtask

  task automatic cmp_mem(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected store at %0t: expected %h got %h", $time, exp, got);
    end
  endtask

  // Read results: notes carry {mask, value}; a zero mask marks a poll
  always @(posedge sys_clk)
  begin
    if (wb_ack_o === 1'b1 && wb_cyc_i === 1'b1 && wb_we_i === 1'b0)
    begin
      note = (rd_q.size() != 0) ? rd_q.pop_front() : 64'hFFFFFFFF_FFFFFFFF;
      if (note[63:32] != 32'h0)
        cmp_rd(note[31:0], note[63:32], wb_dat_o);
    end
  end

  // Data memory writes: an unexpected strobe meets an impossible note
  always @(posedge sys_clk)
  begin
    if (mem_we === 1'b1)
      cmp_mem((mem_q.size() != 0) ? mem_q.pop_front() : 32'hFFFFFFFF, {8'h00, mem_addr, mem_wdata});
  end

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    input logic [3:0] sel, input logic [63:0] nt);
    int k;
    @(posedge sys_clk);
    if (!we)
      rd_q.push_back(nt);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    k = 0;
    do
    begin
      @(posedge sys_clk);
      k++;
    end
    while (wb_ack_o !== 1'b1 && k < 100);
    if (k >= 100)
      err_total++;
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb(1'b1, adr, dat, 4'hF, 64'h0);
  endtask

  task automatic rdx(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] mask);
    wb(1'b0, adr, 32'h0, 4'hF, {mask, exp});
  endtask

  // Issue an instruction, then poll until the sequencer is idle again
  task automatic issue(input logic [13:0] op);
    int k;
    wr(IMR_OFS_INSTR, {18'h0, op});
    k = 0;
    do
    begin
      rdx(IMR_OFS_INSTR, 32'h0, 32'h0);
      k++;
    end
    while (rd[15] !== 1'b0 && k < 50);
    if (rd[15] !== 1'b0)
      err_total++;
  endtask

  task automatic store(input logic sel_p, input logic [1:0] pmode, input logic rel,
    input logic [5:0] k, input logic [15:0] p, input logic [7:0] acc);
    logic [15:0] ea, pn;
    logic [7:0] ofs_p, ofs_o;
    ofs_p = sel_p ? IMR_OFS_PTR1 : IMR_OFS_PTR0;
    ofs_o = sel_p ? IMR_OFS_PTR0 : IMR_OFS_PTR1;
    ea = rel ? p + {{10{k[5]}}, k} : (pmode == IMR_MODE_PREINC) ? p + 16'h0001 :
      (pmode == IMR_MODE_PREDEC) ? p - 16'h0001 : p;
    pn = rel ? p : pmode[0] ? p - 16'h0001 : p + 16'h0001;
    wr(IMR_OFS_ACC, {24'h0, acc});
    wr(ofs_p, {16'h0, p});
    wr(ofs_o, 32'h00005A5A);
    mem_q.push_back({8'h00, ea, acc});
    issue(rel ? {IMR_OP_STREL_HI, sel_p, k} : {IMR_OP_STORE_HI, sel_p, pmode});
    rdx(ofs_p, {16'h0, pn}, 32'h0000FFFF);
    rdx(ofs_o, 32'h00005A5A, 32'h0000FFFF);
    rdx(IMR_OFS_STATUS, {24'h0, IMR_STATUS_RST}, 32'hFF);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    summarize();
  end

  initial
  begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(49));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    cmp_rd(32'h1, 32'h1, {31'h0, dev_reset_n});
    rdx(IMR_OFS_PWRCTL, {24'h0, IMR_PWRCTL_RST}, 32'hFF);
    rdx(IMR_OFS_INTCTL, {24'h0, IMR_INTCTL_RST}, 32'hFF);
    wr(8'h40, 32'hFF);
    rdx(8'h40, 32'h0, 32'hFFFFFFFF);
    // Every mode at the pointer boundary it wraps across, both pointers
    for (int i = 0; i < 8; i++)
      store(i[2], i[1:0], 1'b0, 6'h00, i[0] ? 16'h0000 : 16'hFFFF, 8'($urandom));
    for (int i = 0; i < 12; i++)
      store(1'($urandom), 2'($urandom), 1'($urandom), 6'($urandom), 16'($urandom),
        8'($urandom));
    store(1'b0, 2'h0, 1'b1, 6'h20, 16'h0010, 8'hC3);
    store(1'b1, 2'h3, 1'b1, 6'h1F, 16'hFFF0, 8'h3C);
    // Byte lane 0 disabled leaves the accumulator alone
    wr(IMR_OFS_ACC, 32'h11);
    wb(1'b1, IMR_OFS_ACC, 32'hEE, 4'hE, 64'h0);
    rdx(IMR_OFS_ACC, 32'h11, 32'hFF);
    wr(IMR_OFS_PC, 32'h1234);
    issue(IMR_OP_NOP);
    rdx(IMR_OFS_PC, 32'h1235, 32'h7FFF);
    rdx(IMR_OFS_ACC, 32'h11, 32'hFF);
    rdx(IMR_OFS_STATUS, {24'h0, IMR_STATUS_RST}, 32'hFF);
    // Two nested returns pop in reverse order
    a1 = 15'($urandom);
    a2 = 15'($urandom);
    wr(IMR_OFS_INTCTL, 32'h0);
    wr(IMR_OFS_PUSH, {17'h0, a1});
    wr(IMR_OFS_PUSH, {17'h0, a2});
    issue(IMR_OP_RETFI);
    rdx(IMR_OFS_PC, {17'h0, a2}, 32'h7FFF);
    rdx(IMR_OFS_INTCTL, 32'h80, 32'h80);
    rdx(IMR_OFS_PUSH, 32'h1, 32'h1F);
    rdx(IMR_OFS_STATUS, {24'h0, IMR_STATUS_RST}, 32'hFF);
    wr(IMR_OFS_INTCTL, 32'h0);
    issue(IMR_OP_RETFI);
    rdx(IMR_OFS_PC, {17'h0, a1}, 32'h7FFF);
    rdx(IMR_OFS_INTCTL, 32'h80, 32'h80);
    rdx(IMR_OFS_PUSH, 32'h0, 32'h1F);
    // Software reset with state to clear
    wr(IMR_OFS_PUSH, 32'h0123);
    wr(IMR_OFS_INSTR, {18'h0, IMR_OP_RESET});
    n = 0;
    while (dev_reset_n !== 1'b0 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    cmp_rd(32'h0, 32'h1, {31'h0, dev_reset_n});
    while (dev_reset_n !== 1'b1 && n < 60)
    begin
      @(posedge sys_clk);
      n++;
    end
    cmp_rd(32'h1, 32'h1, {31'h0, dev_reset_n});
    repeat (4) @(posedge sys_clk);
    rdx(IMR_OFS_PWRCTL, 32'h0, 32'h4);
    rdx(IMR_OFS_INTCTL, 32'h0, 32'h80);
    rdx(IMR_OFS_PUSH, 32'h0, 32'h1F);
    repeat (3) @(posedge sys_clk);
    summarize();
  end
endmodule // indirect_move_return_reset_exec_tb_top
